// File: core/trl_pkg.sv
// package for the touch report and low-power scheduling block
package trl_pkg;
    // register offsets
    localparam logic [7:0] OFS_QUEUE = 8'h00;
    localparam logic [7:0] OFS_FAULT = 8'h01;
    localparam logic [7:0] OFS_STATE = 8'h02;
    localparam logic [7:0] OFS_SLEEP = 8'h11;
    // field positions
    localparam int MORE_POS      = 7;
    localparam int EMPTY_POS     = 6;
    localparam int OVFL_POS      = 5;
    localparam int PRESS_POS     = 4;
    localparam int IDLE_MSB      = 7;
    localparam int IDLE_LSB      = 5;
    localparam int SLEEP_MSB     = 4;
    localparam int KEYLIM_POS    = 4;
    // reset values and fault codes
    localparam logic [7:0] SLEEP_CFG_RST = 8'h00;
    localparam logic [1:0] FAULT_NONE    = 2'h0;
    localparam logic [1:0] FAULT_GND     = 2'h1;
    localparam logic [1:0] FAULT_SUPPLY  = 2'h2;
    // timing: 8 ms base at 40 MHz
    localparam int  CLK_HZ      = 40000000;
    localparam int  BASE_MS     = 8;
    localparam int  BASE_CYC    = CLK_HZ / 1000 * BASE_MS;
    localparam int  DEBOUNCE_K  = 4;
    localparam int  IDLE_K      = 6;
    localparam int  TICK_OFFS   = 5;
    localparam int  TICK_DIV    = 8;
    localparam int  QUEUE_DEPTH = 30;

    // one queued event
    typedef struct packed {
        logic       press;
        logic [3:0] index;
    } trl_event_t;

    // host register access strobe group
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } trl_req_t;

    // scheduler states
    typedef enum logic [1:0] {
        SCH_NORMAL = 2'b01,
        SCH_SLEEP  = 2'b10
    } trl_sched_t;
endpackage

// File: core/trl_touch_report.sv
// touch report, event queue, fault register and low-power scan scheduler
`timescale 1ns/1ps
`default_nettype none
module trl_touch_report #(
    parameter int DEPTH     = trl_pkg::QUEUE_DEPTH,
    parameter int BASE_CYCS = trl_pkg::BASE_CYC
) (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire trl_pkg::trl_req_t hostReq,        // register access strobes
    output logic [7:0]             hostRdata,      // read data, one cycle late
    input  wire logic              scan_enable_bit,
    input  wire logic              duty_cycle_bit_n,
    input  wire logic [7:0]        tick_code,
    input  wire logic [7:0]        sample_period,  // from pad config
    input  wire logic [3:0]        max_key_count,  // from pad config
    input  wire logic [7:0]        padTouched,     // debounced touch levels
    input  wire logic              shortGnd,       // short found this scan
    input  wire logic              shortSupply,
    output logic                   scanHalt,       // scanning stopped
    output logic                   scanTick,       // one scan per pulse
    output logic                   sleepActive,
    output logic                   dataIrq,
    output logic                   faultIrq
);
    import trl_pkg::*;

    localparam int AW = $clog2(DEPTH + 1);
    // pointer and count width: the count must reach DEPTH itself,
    // so it needs one more code than the pointers strictly use
    // hazards kept in mind throughout this module:
    // - a host read and a new event may land in the same cycle
    // - a host write to the queue beats any event in that cycle
    // - a short seen in the clearing cycle must not be lost
    // - the read byte is built from pre-pop state, so the flags
    //   describe the entry being handed over, not the next one
    // - scheduler lengths are products of live config inputs,
    //   so a change of tick or sample period takes effect at once

    // register state
    logic [7:0]       sleep_schedule_config, next_sleep_schedule_config;
    logic [7:0]       electrode_touch_state, next_electrode_touch_state;
    logic [1:0]       faultCode, next_faultCode;
    logic             keyLimit, next_keyLimit;
    logic             overflow, next_overflow;
    logic [7:0]       prevTouched, next_prevTouched;
    trl_event_t       queue [DEPTH];
    logic [AW-1:0]    rdPtr, wrPtr, count;
    logic [AW-1:0]    next_rdPtr, next_wrPtr, next_count;
    logic [7:0]       next_hostRdata;
    logic             next_dataIrq, next_faultIrq, dataArmed, next_dataArmed;

    // decoded strobes
    // each strobe is one cycle wide, decoded on the edge it is taken
    // stop mode is any mode with scanning disabled; only there may
    // the host clear the fault code
    logic queueRd, queueWr, faultWr, dutyRun, stopMode;
    logic pushEv;
    trl_event_t newEv;
    assign queueRd  = hostReq.rd && hostReq.addr == OFS_QUEUE;
    assign queueWr  = hostReq.wr && hostReq.addr == OFS_QUEUE;
    assign faultWr  = hostReq.wr && hostReq.addr == OFS_FAULT;
    assign dutyRun  = scan_enable_bit && !duty_cycle_bit_n;
    assign stopMode = !scan_enable_bit;

    // lowest changed electrode becomes this cycle's event
    always_comb begin
        pushEv = 1'b0;
        newEv  = '0;
        for (int i = 7; i >= 0; i--) begin
            if (padTouched[i] != prevTouched[i]) begin
                pushEv      = 1'b1;
                newEv.press = padTouched[i];
                newEv.index = 4'(i);
            end
        end
    end

    // lowest touched pad wins the instantaneous view
    function automatic logic [7:0] one_pad(input logic [7:0] t);
        logic [7:0] r;
        r = t & (~t + 8'h01);
        return r;
    endfunction

    // pressed key count for the limit check
    function automatic logic [3:0] pop8(input logic [7:0] t);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) c = c + {3'h0, t[i]};
        return c;
    endfunction

    // queue, status, fault and read-data next values
    // order of precedence inside this process, last one wins:
    //   pop on read, then push of a new event,
    //   then a host write that empties the queue
    // the fault latch holds the first code until a stop-mode write;
    // ground is checked before supply, so it wins a tie
    // the data interrupt fires once per empty-to-nonempty change
    // and is rearmed only when the queue drains again
    // read data is zero in every cycle without a read strobe
    always_comb begin
        next_rdPtr    = rdPtr;
        next_wrPtr    = wrPtr;
        next_count    = count;
        next_overflow = overflow;
        next_prevTouched = prevTouched;
        next_sleep_schedule_config = sleep_schedule_config;
        next_electrode_touch_state = one_pad(padTouched);
        next_keyLimit = pop8(padTouched) > max_key_count;
        next_faultCode = faultCode;
        next_dataArmed = dataArmed;
        next_dataIrq   = dataIrq;
        next_faultIrq  = faultIrq;
        next_hostRdata = 8'h00;
        if (!scanHalt) next_prevTouched = padTouched;
        // pop on read
        if (queueRd && count != '0) begin
            next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            next_count = next_count - 1'b1;
        end
        // push new event, drop when full
        if (pushEv && !scanHalt) begin
            if (count == AW'(DEPTH) && !queueRd) begin
                next_overflow = 1'b1;
            end else begin
                next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
                next_count = next_count + 1'b1;
            end
        end
        // host write empties everything
        if (queueWr) begin
            next_rdPtr    = '0;
            next_wrPtr    = '0;
            next_count    = '0;
            next_overflow = 1'b0;
        end
        // clear in stop mode first, so a new short can set again
        if (faultWr && stopMode) begin
            next_faultCode = FAULT_NONE;
            next_faultIrq  = 1'b0;
        end
        // first fault latched; a short in the clearing cycle wins
        if (faultCode == FAULT_NONE || (faultWr && stopMode)) begin
            if (shortGnd) next_faultCode = FAULT_GND;
            else if (shortSupply) next_faultCode = FAULT_SUPPLY;
        end
        if ((faultCode == FAULT_NONE || (faultWr && stopMode)) &&
            next_faultCode != FAULT_NONE)
            next_faultIrq = 1'b1;
        // sleep config write
        if (hostReq.wr && hostReq.addr == OFS_SLEEP)
            next_sleep_schedule_config = hostReq.wdata;
        // data interrupt: fires on empty going low, once
        if (queueRd || queueWr) next_dataIrq = 1'b0;
        if (next_count == '0) next_dataArmed = 1'b1;
        else if (count == '0 && dataArmed) begin
            next_dataIrq   = 1'b1;
            next_dataArmed = 1'b0;
        end
        // read mux
        if (hostReq.rd) begin
            unique case (hostReq.addr)
                OFS_QUEUE: begin
                    next_hostRdata[MORE_POS]  = count > AW'(1);
                    next_hostRdata[EMPTY_POS] = count == '0;
                    next_hostRdata[OVFL_POS]  = overflow;
                    if (count != '0) begin
                        next_hostRdata[PRESS_POS]  = queue[rdPtr].press;
                        next_hostRdata[3:0] = queue[rdPtr].index;
                    end
                end
                OFS_FAULT: begin
                    next_hostRdata[KEYLIM_POS] = keyLimit;
                    next_hostRdata[1:0] = faultCode;
                end
                OFS_STATE: next_hostRdata = electrode_touch_state;
                OFS_SLEEP: next_hostRdata = sleep_schedule_config;
                default:   next_hostRdata = 8'h00;
            endcase
        end
    end

    // register the queue group
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdPtr       <= '0;
            wrPtr       <= '0;
            count       <= '0;
            overflow    <= 1'b0;
            prevTouched <= 8'h00;
            sleep_schedule_config <= SLEEP_CFG_RST;
            electrode_touch_state <= 8'h00;
            keyLimit    <= 1'b0;
            faultCode   <= FAULT_NONE;
            dataArmed   <= 1'b1;
            dataIrq     <= 1'b0;
            faultIrq    <= 1'b0;
            hostRdata   <= 8'h00;
            scanHalt    <= 1'b0;
        end else begin
            rdPtr       <= next_rdPtr;
            wrPtr       <= next_wrPtr;
            count       <= next_count;
            overflow    <= next_overflow;
            prevTouched <= next_prevTouched;
            sleep_schedule_config <= next_sleep_schedule_config;
            electrode_touch_state <= next_electrode_touch_state;
            keyLimit    <= next_keyLimit;
            faultCode   <= next_faultCode;
            dataArmed   <= next_dataArmed;
            dataIrq     <= next_dataIrq;
            faultIrq    <= next_faultIrq;
            hostRdata   <= next_hostRdata;
            scanHalt    <= next_faultCode != FAULT_NONE;
        end
    end

    // queue storage, written with no reset
    always_ff @(posedge mclk) begin
        if (pushEv && !scanHalt && !queueWr &&
            !(count == AW'(DEPTH) && !queueRd))
            queue[wrPtr] <= newEv;
    end

    // ---- scan scheduler ----
    // all lengths are counted in mclk cycles; BASE_CYCS is the base
    // step, shortened in simulation to keep runs brief
    // a zero sample period gives a zero length and a tick each
    // cycle; the pad config block is expected to avoid that value
    // idle time counts only cycles with no pad touched at all
    // leaving duty-cycled run forces the normal period at once
    logic [2:0]  idleFactor;
    logic [4:0]  sleepFactor;
    logic        lowPowerOn;
    logic [31:0] unitCyc;       // cycles of ((tick+5)/8+1) x sample x 8 ms
    trl_sched_t  sched, next_sched;
    logic [31:0] periodCnt, next_periodCnt;
    logic [31:0] idleCnt, next_idleCnt;
    logic        next_scanTick;
    logic [31:0] periodLen, idleLen;

    assign idleFactor  = sleep_schedule_config[IDLE_MSB:IDLE_LSB];
    assign sleepFactor = sleep_schedule_config[SLEEP_MSB:0];
    assign lowPowerOn  = dutyRun && idleFactor != 3'h0 &&
                         sleepFactor != 5'h00;
    assign unitCyc = 32'(((32'(tick_code) + TICK_OFFS) / TICK_DIV + 1) *
                         32'(sample_period) * BASE_CYCS);
    assign idleLen = 32'(unitCyc * 32'(idleFactor) * IDLE_K);
    assign periodLen = (sched == SCH_SLEEP) ?
        32'(unitCyc * 32'(sleepFactor) * DEBOUNCE_K) :
        32'(unitCyc * DEBOUNCE_K);

    // next scheduler state
    // the period counter restarts on every change of state, so the
    // first period after a change is always a whole one
    // a touch in sleep returns to normal on the next edge
    always_comb begin
        next_sched     = sched;
        next_periodCnt = periodCnt + 32'h1;
        next_idleCnt   = idleCnt;
        next_scanTick  = 1'b0;
        if (periodCnt + 32'h1 >= periodLen) begin
            next_periodCnt = 32'h0;
            next_scanTick  = !scanHalt;
        end
        unique case (sched)
            SCH_NORMAL: begin
                if (padTouched != 8'h00 || !lowPowerOn)
                    next_idleCnt = 32'h0;
                else if (idleCnt + 32'h1 >= idleLen) begin
                    next_sched     = SCH_SLEEP;
                    next_idleCnt   = 32'h0;
                    next_periodCnt = 32'h0;
                end else
                    next_idleCnt = idleCnt + 32'h1;
            end
            SCH_SLEEP: begin
                if (padTouched != 8'h00 || !lowPowerOn) begin
                    next_sched     = SCH_NORMAL;
                    next_periodCnt = 32'h0;
                end
            end
            default: next_sched = SCH_NORMAL;
        endcase
        if (!dutyRun) next_sched = SCH_NORMAL;
    end

    // register the scheduler
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sched       <= SCH_NORMAL;
            periodCnt   <= 32'h0;
            idleCnt     <= 32'h0;
            scanTick    <= 1'b0;
            sleepActive <= 1'b0;
        end else begin
            sched       <= next_sched;
            periodCnt   <= next_periodCnt;
            idleCnt     <= next_idleCnt;
            scanTick    <= next_scanTick;
            sleepActive <= next_sched == SCH_SLEEP;
        end
    end
endmodule
`default_nettype wire

// File: tb/trl_touch_report_props.sv
// checker for the touch report block, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module trl_touch_report_props (
    input wire logic              mclk,
    input wire logic              arst_n,
    input wire trl_pkg::trl_req_t hostReq,
    input wire logic [7:0]        hostRdata,
    input wire logic              scan_enable_bit,
    input wire logic              duty_cycle_bit_n,
    input wire logic [7:0]        padTouched,
    input wire logic              shortGnd,
    input wire logic              shortSupply,
    input wire logic              scanHalt,
    input wire logic              scanTick,
    input wire logic              sleepActive,
    input wire logic              dataIrq,
    input wire logic              faultIrq
);
    import trl_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic fltWr;  // accepted fault clearing write
    logic qAcc;   // any queue access
    assign fltWr = hostReq.wr && hostReq.addr == OFS_FAULT && !scan_enable_bit;
    assign qAcc = (hostReq.rd || hostReq.wr) && hostReq.addr == OFS_QUEUE;
    state_onehot_a: assert property (hostReq.rd && hostReq.addr == OFS_STATE
        |=> $onehot0(hostRdata)) else $error("status shows two pads");
    queue_flags_a: assert property (hostReq.rd && hostReq.addr == OFS_QUEUE
        |=> !(hostRdata[MORE_POS] && hostRdata[EMPTY_POS]))
        else $error("more and empty both set");
    halt_start_a: assert property ((shortGnd || shortSupply) && !fltWr
        |=> scanHalt) else $error("short did not halt scanning");
    halt_hold_a: assert property (scanHalt && !fltWr |=> scanHalt)
        else $error("halt dropped without clear");
    halt_clear_a: assert property (scanHalt && fltWr && !shortGnd
        && !shortSupply |=> !scanHalt) else $error("fault not cleared");
    fault_irq_a: assert property ($rose(scanHalt) |-> ##[0:1] faultIrq)
        else $error("fault interrupt missing");
    sleep_mode_a: assert property ((!scan_enable_bit || duty_cycle_bit_n)[*2]
        |-> !sleepActive) else $error("sleep outside duty run");
    wake_touch_a: assert property (sleepActive && padTouched != 8'h00
        |-> ##[1:2] !sleepActive) else $error("touch did not wake");
    tick_pulse_a: assert property (scanTick |=> !scanTick)
        else $error("scan tick longer than a cycle");
    data_irq_a: assert property (dataIrq && qAcc |=> !dataIrq)
        else $error("data interrupt not cleared");
endmodule
bind trl_touch_report trl_touch_report_props trl_touch_report_props_i (
    .mclk, .arst_n, .hostReq, .hostRdata, .scan_enable_bit, .duty_cycle_bit_n,
    .padTouched, .shortGnd, .shortSupply, .scanHalt, .scanTick, .sleepActive,
    .dataIrq, .faultIrq);
`default_nettype wire

// File: tb/trl_host_model.sv
// host side model issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
module trl_host_model (
    input  wire logic            mclk,
    output var trl_pkg::trl_req_t hostReq
);
    import trl_pkg::*;
    initial hostReq = '{rd: 1'b0, wr: 1'b0, addr: 8'hFF, wdata: 8'hFF};
    // one strobe cycle, then release with inverted address and data
    task automatic access(logic isRd, logic [7:0] addr, logic [7:0] wdata);
        @(negedge mclk);
        hostReq = '{rd: isRd, wr: ~isRd, addr: addr, wdata: wdata};
        @(negedge mclk);
        hostReq = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    endtask
endmodule
`default_nettype wire

// File: tb/trl_touch_report_test.sv
// self-checking bench for the touch report block
`timescale 1ns/1ps
`default_nettype none
module trl_touch_report_test;
    import trl_pkg::*;
    localparam int BCYC = 4;  // shortened 8 ms base
    logic       mclk = 1'b0, arst_n = 1'b0, scan_enable_bit = 1'b0;
    logic       duty_cycle_bit_n = 1'b1, shortGnd = 1'b0, shortSupply = 1'b0;
    logic [7:0] tick_code = 8'h00, sample_period = 8'h02, padTouched = 8'h00;
    logic [3:0] max_key_count = 4'h8;
    logic [7:0] hostRdata, r;
    logic       scanHalt, scanTick, sleepActive, dataIrq, faultIrq;
    trl_req_t   hostReq;
    int         failures = 0, n_compared = 0, n, unit;
    logic [7:0] expQ[$];          // read results awaiting the monitor
    logic [4:0] evQ[$];           // reference event queue
    logic       ovf = 1'b0, rdSeen = 1'b0;
    always #12.5 mclk = ~mclk;
    trl_touch_report #(.DEPTH(30), .BASE_CYCS(BCYC)) trl_touch_report_i (
        .mclk, .arst_n, .hostReq, .hostRdata, .scan_enable_bit,
        .duty_cycle_bit_n, .tick_code, .sample_period, .max_key_count,
        .padTouched, .shortGnd, .shortSupply, .scanHalt, .scanTick,
        .sleepActive, .dataIrq, .faultIrq);
    trl_host_model trl_host_model_i (.mclk, .hostReq);
    task automatic cmpRead(logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD hostRdata expected %h seen %h", e, g);
        end
    endtask
    task automatic cmpLevel(string what, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    // monitor: a read answers one cycle after its strobe edge
    always @(posedge mclk) rdSeen <= hostReq.rd;
    always @(negedge mclk) begin
        if (rdSeen === 1'b1 && expQ.size() > 0)
            cmpRead(expQ.pop_front(), hostRdata);
    end
    task automatic rdx(logic [7:0] a, logic [7:0] e);
        expQ.push_back(e);
        trl_host_model_i.access(1'b1, a, 8'h00);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        trl_host_model_i.access(1'b0, a, d);
    endtask
    task automatic cyc(int k);
        repeat (k) @(negedge mclk);
    endtask
    // expected queue byte from the reference copy, then pop
    task automatic popChk();
        logic [7:0] e;
        e = {evQ.size() > 1, evQ.size() == 0, ovf, 5'h00};
        if (evQ.size() > 0) e[4:0] = evQ.pop_front();
        rdx(OFS_QUEUE, e);
    endtask
    // toggle one pad, noting the event it should queue
    task automatic evt(int idx);
        @(negedge mclk);
        padTouched[idx] = ~padTouched[idx];
        if (evQ.size() < 30) evQ.push_back({padTouched[idx], idx[3:0]});
        else ovf = 1'b1;
    endtask
    // cycles between two scan pulses
    task automatic tickGap(output int k);
        k = 0;
        while (scanTick !== 1'b1 && k < 3000) begin cyc(1); k++; end
        k = 1;
        cyc(1);
        while (scanTick !== 1'b1 && k < 3000) begin cyc(1); k++; end
    endtask
    task automatic end_of_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog, far beyond the expected run length
    initial begin
        #(20000 * 25);
        failures++;
        end_of_test();
    end
    initial begin
        r = 8'($urandom(45902));
        cyc(4);
        arst_n = 1'b1;
        rdx(OFS_SLEEP, SLEEP_CFG_RST);
        popChk();
        rdx(OFS_FAULT, 8'h00);
        rdx(8'h05, 8'h00);
        r = 8'($urandom());
        wr(OFS_SLEEP, r);
        rdx(OFS_SLEEP, r);
        wr(OFS_STATE, 8'hFF);
        for (int i = 0; i < 5; i++) evt($urandom_range(7, 0));
        cyc(2);
        rdx(OFS_STATE, padTouched & (~padTouched + 8'h01));
        cmpLevel("dataIrq", 8'h01, {7'h00, dataIrq});
        repeat (6) popChk();
        cmpLevel("dataIrq", 8'h00, {7'h00, dataIrq});
        for (int i = 0; i < 32; i++) evt(i % 8);
        cyc(2);
        popChk();
        wr(OFS_QUEUE, 8'h00);
        evQ.delete();
        ovf = 1'b0;
        popChk();
        max_key_count = 4'h1;
        padTouched = 8'h03;
        cyc(3);
        rdx(OFS_FAULT, 8'h10);
        padTouched = 8'h00;
        max_key_count = 4'h8;
        cyc(2);
        wr(OFS_QUEUE, 8'h00);
        scan_enable_bit = 1'b1;
        {shortGnd, shortSupply} = 2'b11;
        cyc(1);
        {shortGnd, shortSupply} = 2'b00;
        cyc(2);
        cmpLevel("faultIrq", 8'h01, {7'h00, faultIrq});
        cmpLevel("scanHalt", 8'h01, {7'h00, scanHalt});
        rdx(OFS_FAULT, {6'h00, FAULT_GND});
        padTouched[3] = 1'b1;
        cyc(2);
        padTouched[3] = 1'b0;
        popChk();
        wr(OFS_FAULT, 8'h00);
        rdx(OFS_FAULT, {6'h00, FAULT_GND});
        scan_enable_bit = 1'b0;
        wr(OFS_FAULT, 8'h00);
        rdx(OFS_FAULT, 8'h00);
        scan_enable_bit = 1'b1;
        shortSupply = 1'b1;
        cyc(1);
        shortSupply = 1'b0;
        cyc(2);
        rdx(OFS_FAULT, {6'h00, FAULT_SUPPLY});
        scan_enable_bit = 1'b0;
        wr(OFS_FAULT, 8'h00);
        wr(OFS_SLEEP, 8'h22);
        scan_enable_bit = 1'b1;
        cyc(120);
        cmpLevel("sleepActive", 8'h00, {7'h00, sleepActive});
        unit = ((tick_code + TICK_OFFS) / TICK_DIV + 1) * sample_period * BCYC;
        padTouched[0] = 1'b1;
        duty_cycle_bit_n = 1'b0;
        tickGap(n);
        cmpLevel("normal gap", 8'(unit * DEBOUNCE_K), 8'(n));
        padTouched[0] = 1'b0;
        cyc(unit * IDLE_K - 8);
        cmpLevel("sleepActive", 8'h00, {7'h00, sleepActive});
        n = 0;
        while (sleepActive !== 1'b1 && n < 30) begin cyc(1); n++; end
        cmpLevel("sleepActive", 8'h01, {7'h00, sleepActive});
        tickGap(n);
        tickGap(n);
        cmpLevel("sleep gap", 8'(unit * 2 * DEBOUNCE_K), 8'(n));
        padTouched[0] = 1'b1;
        cyc(3);
        cmpLevel("sleepActive", 8'h00, {7'h00, sleepActive});
        cyc(4);
        end_of_test();
    end
endmodule
`default_nettype wire
